// ### dss_drive_sel.sv
// Drive select decode and step/direction front end with an APB register slave.
// Assumes cable lines and jumper straps are asynchronous; APB shares clk.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "dss_params.svh"
module dss_drive_sel #(
    parameter int ADDR_W = 8,
    parameter int TW = 7,
    parameter int TRACK_MAX = `DSS_TRACK_MAX
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller cable, active low
    input wire logic [`DSS_NUM_LINES-1:0] cable_n,
    // Address straps, high when shorted
    input wire logic select_addr_jumper_one,
    input wire logic select_addr_jumper_two,
    input wire logic select_addr_jumper_three,
    input wire logic select_addr_jumper_four,
    // Head mechanism
    output logic motor_step,
    output logic motor_inward,
    output logic [TW-1:0] track_pos,
    output logic drive_selected
);
    if (ADDR_W < 8 || ADDR_W > 32) begin : bad_addr
        $error("dss_drive_sel: ADDR_W must be 8 to 32");
    end
    if (`DSS_DIR_SETUP_CYC >= 2 ** `DSS_DIR_CNT_W) begin : bad_cnt
        $error("dss_drive_sel: setup counter too narrow");
    end

    localparam logic [2:0] IX_CTRL = 3'h0;
    localparam logic [2:0] IX_STATUS = 3'h1;
    localparam logic [2:0] IX_TRACK = 3'h2;
    localparam logic [2:0] IX_LINES = 3'h3;
    localparam logic [2:0] IX_STEPS = 3'h4;
    localparam logic [2:0] IX_NONE = 3'h7;

    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = IX_NONE;
        if (a == ADDR_W'(`DSS_OFF_CTRL)) reg_index = IX_CTRL;
        if (a == ADDR_W'(`DSS_OFF_STATUS)) reg_index = IX_STATUS;
        if (a == ADDR_W'(`DSS_OFF_TRACK)) reg_index = IX_TRACK;
        if (a == ADDR_W'(`DSS_OFF_LINES)) reg_index = IX_LINES;
        if (a == ADDR_W'(`DSS_OFF_STEPS)) reg_index = IX_STEPS;
    endfunction

    function automatic logic one_hot(input dss_pkg::dss_jumper_t j);
        one_hot = (j != '0) && ((j & (j - 1'b1)) == '0);
    endfunction

    dss_head_if #(.TW(TW)) hif();

    dss_head_pos #(.TW(TW), .TRACK_MAX(TRACK_MAX)) u_head (
        .clk(clk),
        .resetn(resetn),
        .hif(hif.head)
    );

    // Two-stage synchronisers; the first stage feeds only the second
    logic [`DSS_NUM_LINES-1:0] line_m;
    logic [`DSS_NUM_LINES-1:0] line_s;
    dss_pkg::dss_jumper_t jump_m;
    dss_pkg::dss_jumper_t jump_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_m <= '1;
            line_s <= '1;
            jump_m <= '0;
            jump_s <= '0;
        end else begin
            line_m <= cable_n;
            line_s <= line_m;
            jump_m <= {select_addr_jumper_four, select_addr_jumper_three,
                       select_addr_jumper_two, select_addr_jumper_one};
            jump_s <= jump_m;
        end
    end

    dss_pkg::dss_state_t st, next_st;
    dss_pkg::dss_jumper_t jumper, next_jumper;
    logic jumper_ok, next_jumper_ok;
    logic selected, next_selected;
    logic step_prev, next_step_prev;
    logic dir_prev, next_dir_prev;
    logic [`DSS_DIR_CNT_W-1:0] dir_cnt, next_dir_cnt;
    logic step_req, next_step_req;
    logic step_inward, next_step_inward;
    logic clear_pos, next_clear_pos;
    logic setup_err, next_setup_err;
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] steps, next_steps;
    logic [`DSS_NUM_LINES-1:0] lines, next_lines;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic sel_now;
    logic trail;
    logic wr;
    logic [2:0] idx;
    logic [`DSS_NUM_LINES-1:0] mask;

    always_comb begin
        next_st = st;
        next_jumper = jumper;
        next_jumper_ok = jumper_ok;
        case (st)
            dss_pkg::DSS_WAIT: next_st = dss_pkg::DSS_SETTLE;
            dss_pkg::DSS_SETTLE: next_st = dss_pkg::DSS_CAPTURE;
            dss_pkg::DSS_CAPTURE: begin
                // Straps are read once the synchroniser holds post-reset values
                next_jumper = jump_s;
                next_jumper_ok = one_hot(jump_s);
                next_st = dss_pkg::DSS_RUN;
            end
            dss_pkg::DSS_RUN: next_st = dss_pkg::DSS_RUN;
            default: next_st = dss_pkg::DSS_WAIT;
        endcase

        // A faulty strap set never selects, so a chain clash cannot drive the bus twice
        sel_now = (st == dss_pkg::DSS_RUN) && jumper_ok
                  && ((jumper & ~line_s[3:0]) != '0);
        next_selected = sel_now;

        // Trailing edge of step is the low-to-high return of the line
        trail = line_s[`DSS_LN_STEP] && !step_prev;
        next_step_prev = line_s[`DSS_LN_STEP];
        next_dir_prev = line_s[`DSS_LN_DIR];
        if (line_s[`DSS_LN_DIR] != dir_prev) begin
            next_dir_cnt = '0;
        end else if (dir_cnt != '1) begin
            next_dir_cnt = dir_cnt + 1'b1;
        end else begin
            next_dir_cnt = dir_cnt;
        end

        next_step_req = trail && sel_now && ctrl[`DSS_CTRL_STEP_EN];
        next_step_inward = step_inward;
        if (trail) begin
            next_step_inward = !line_s[`DSS_LN_DIR];
        end

        idx = reg_index(paddr);
        wr = psel && penable && pready && pwrite && (idx != IX_NONE);

        // Direction moved inside the setup window; flag it, set beats clear
        next_setup_err = setup_err;
        if (wr && idx == IX_STATUS && pwdata[`DSS_ST_SETUP_ERR]) begin
            next_setup_err = 1'b0;
        end
        if (next_step_req && dir_cnt < `DSS_DIR_CNT_W'(`DSS_DIR_SETUP_CYC - 1)) begin
            next_setup_err = 1'b1;
        end

        next_ctrl = ctrl;
        if (wr && idx == IX_CTRL) begin
            next_ctrl = pwdata & 32'h0000_0007;
        end
        next_clear_pos = wr && idx == IX_TRACK;
        next_steps = step_req ? steps + 32'h0000_0001 : steps;

        mask = '1;
        mask[`DSS_LN_OPT0] = ctrl[`DSS_CTRL_OPT0];
        mask[`DSS_LN_OPT1] = ctrl[`DSS_CTRL_OPT1];
        next_lines = ~line_s & mask;

        next_pready = psel && !penable;
        next_pslverr = psel && !penable && idx == IX_NONE;
        next_prdata = prdata;
        if (psel && !penable) begin
            case (idx)
                IX_CTRL: next_prdata = ctrl;
                IX_STATUS: next_prdata = {24'h00_0000, jumper, 1'b0, setup_err,
                                          !jumper_ok, selected};
                IX_TRACK: next_prdata = 32'(hif.track);
                IX_LINES: next_prdata = 32'(lines);
                IX_STEPS: next_prdata = steps;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= dss_pkg::DSS_WAIT;
            jumper <= '0;
            jumper_ok <= 1'b0;
            selected <= 1'b0;
            step_prev <= 1'b1;
            dir_prev <= 1'b1;
            dir_cnt <= '0;
            step_req <= 1'b0;
            step_inward <= 1'b0;
            clear_pos <= 1'b0;
            setup_err <= 1'b0;
            ctrl <= `DSS_CTRL_RST;
            steps <= 32'h0000_0000;
            lines <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            st <= next_st;
            jumper <= next_jumper;
            jumper_ok <= next_jumper_ok;
            selected <= next_selected;
            step_prev <= next_step_prev;
            dir_prev <= next_dir_prev;
            dir_cnt <= next_dir_cnt;
            step_req <= next_step_req;
            step_inward <= next_step_inward;
            clear_pos <= next_clear_pos;
            setup_err <= next_setup_err;
            ctrl <= next_ctrl;
            steps <= next_steps;
            lines <= next_lines;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign hif.step_req = step_req;
    assign hif.step_inward = step_inward;
    assign hif.clear_pos = clear_pos;
    assign motor_step = hif.motor_step;
    assign motor_inward = hif.motor_inward;
    assign track_pos = hif.track;
    assign drive_selected = selected;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence step_seen_s(logic inward);
        trail && sel_now && ctrl[`DSS_CTRL_STEP_EN] && (!line_s[`DSS_LN_DIR] == inward);
    endsequence
    sequence step_sent_s(logic inward);
        ##1 (step_req && step_inward == inward);
    endsequence

    select_decode_a: assert property (
        (st == dss_pkg::DSS_RUN && jumper_ok && (jumper & ~line_s[3:0]) != '0)
        |=> drive_selected)
        else $error("own select line low but drive not selected");
    select_ignore_a: assert property (
        ((jumper & ~line_s[3:0]) == '0) |=> !drive_selected)
        else $error("drive selected by a foreign select line");
    low_active_a: assert property (
        drive_selected |-> $past((jumper & ~line_s[3:0]) != '0))
        else $error("selection without a low select line");
    inward_step_a: assert property (
        step_seen_s(1'b1) |-> step_sent_s(1'b1))
        else $error("low direction did not step inward");
    outward_step_a: assert property (
        step_seen_s(1'b0) |-> step_sent_s(1'b0))
        else $error("high direction did not step outward");
    unselected_step_a: assert property (
        (trail && !sel_now) |=> !step_req [*2])
        else $error("step taken while not selected");
    opt_gate_a: assert property (
        !ctrl[`DSS_CTRL_OPT0] |=> !lines[`DSS_LN_OPT0])
        else $error("disabled optional line visible");
    setup_flag_a: assert property (
        (next_step_req && dir_cnt < `DSS_DIR_CNT_W'(`DSS_DIR_SETUP_CYC / 2)) |=> setup_err)
        else $error("direction change at step not flagged");
    apb_ready_a: assert property (
        (psel && !penable) |=> (pready && pslverr == (idx == IX_NONE)))
        else $error("APB access phase not answered");
endmodule

// ### dss_params.svh
// Constants of the drive select and step/direction block: offsets, fields, resets, timing.
// Assumes the includer works in a 50 MHz clock domain with 32-bit APB data.
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH
// Register byte offsets
`define DSS_OFF_CTRL 8'h00
`define DSS_OFF_STATUS 8'h04
`define DSS_OFF_TRACK 8'h08
`define DSS_OFF_LINES 8'h0C
`define DSS_OFF_STEPS 8'h10
// Control fields and reset value
`define DSS_CTRL_OPT0 0
`define DSS_CTRL_OPT1 1
`define DSS_CTRL_STEP_EN 2
`define DSS_CTRL_RST 32'h0000_0004
// Status fields
`define DSS_ST_SELECTED 0
`define DSS_ST_JUMP_FAULT 1
`define DSS_ST_SETUP_ERR 2
// Cable line positions, all active low on the wire
`define DSS_NUM_LINES 12
`define DSS_LN_DIR 4
`define DSS_LN_STEP 5
`define DSS_LN_OPT0 10
`define DSS_LN_OPT1 11
// Timing
`define DSS_CLK_MHZ 50
`define DSS_DIR_SETUP_NS 1000
`define DSS_DIR_SETUP_CYC ((`DSS_DIR_SETUP_NS * `DSS_CLK_MHZ + 999) / 1000)
`define DSS_DIR_CNT_W 7
// Head travel
`define DSS_TRACK_MAX 76
`endif

// ### dss_pkg.sv
// Types shared by the drive select and step/direction block.
// Assumes nothing beyond a SystemVerilog compiler.
package dss_pkg;
    typedef enum logic [1:0] {
        DSS_WAIT = 2'b00,
        DSS_SETTLE = 2'b01,
        DSS_CAPTURE = 2'b10,
        DSS_RUN = 2'b11
    } dss_state_t;
    typedef logic [3:0] dss_jumper_t;
endpackage

// ### dss_head_if.sv
// Carrier between the select/step front end and the head position unit.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface dss_head_if #(parameter int TW = 7);
    logic step_req;
    logic step_inward;
    logic clear_pos;
    logic [TW-1:0] track;
    logic motor_step;
    logic motor_inward;
    modport ctl(output step_req, output step_inward, output clear_pos,
                input track, input motor_step, input motor_inward);
    modport head(input step_req, input step_inward, input clear_pos,
                 output track, output motor_step, output motor_inward);
endinterface

// ### dss_head_pos.sv
// Head position unit: one track per accepted step, clamped to the travel range.
// Assumes step requests come one cycle wide from the front end on the same clock.
`timescale 1ns/10ps
`include "dss_params.svh"
module dss_head_pos #(
    parameter int TW = 7,
    parameter int TRACK_MAX = `DSS_TRACK_MAX
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Front end
    dss_head_if.head hif
);
    logic [TW-1:0] track;
    logic motor_step;
    logic motor_inward;
    logic [TW-1:0] next_track;
    logic next_motor_step;
    logic next_motor_inward;

    if (TRACK_MAX < 1 || TRACK_MAX >= 2 ** TW) begin : bad_range
        $error("dss_head_pos: TRACK_MAX does not fit TW");
    end

    always_comb begin
        next_track = track;
        next_motor_step = 1'b0;
        next_motor_inward = motor_inward;
        if (hif.clear_pos) begin
            next_track = '0;
        end else if (hif.step_req) begin
            next_motor_inward = hif.step_inward;
            // Exactly one track per step; the stops at either end swallow the pulse
            if (hif.step_inward && track < TW'(TRACK_MAX)) begin
                next_track = track + 1'b1;
                next_motor_step = 1'b1;
            end else if (!hif.step_inward && track != '0) begin
                next_track = track - 1'b1;
                next_motor_step = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            track <= '0;
            motor_step <= 1'b0;
            motor_inward <= 1'b0;
        end else begin
            track <= next_track;
            motor_step <= next_motor_step;
            motor_inward <= next_motor_inward;
        end
    end

    assign hif.track = track;
    assign hif.motor_step = motor_step;
    assign hif.motor_inward = motor_inward;

    one_track_a: assert property (@(posedge clk) disable iff (!resetn)
        (hif.step_req && !hif.clear_pos && track != '0 && track != TW'(TRACK_MAX))
        |=> (motor_step && (track == $past(track) + 1'b1 || track == $past(track) - 1'b1)))
        else $error("step did not move the head by one track");
endmodule

// ### dss_host_model.sv
// Host controller model driving the active-low cable of the drive select block.
// Assumes clk is the block clock; undriven lines sit high as with the pull-ups.
`timescale 1ns/10ps
`include "dss_params.svh"
module dss_host_model (
    // Clock
    input wire logic clk,
    // Cable, active low
    output logic [`DSS_NUM_LINES-1:0] cable_n
);
    // All twelve lines idle high, i.e. deasserted
    initial cable_n = {`DSS_NUM_LINES{1'b1}};
    // Assert one select line; idx 4 releases all of them
    task automatic sel(input int idx);
        @(posedge clk);
        cable_n[3:0] <= ~(4'h1 << idx);
    endtask
    task automatic set_line(input int idx, input logic asserted);
        @(posedge clk);
        cable_n[idx] <= ~asserted;
    endtask
    // Direction leads the trailing edge by setup + 5 cycles; the pulse is 4 cycles low
    task automatic step(input logic inward, input int setup);
        @(posedge clk);
        cable_n[`DSS_LN_DIR] <= ~inward;
        repeat (setup + 1) @(posedge clk);
        cable_n[`DSS_LN_STEP] <= 1'b0;
        repeat (4) @(posedge clk);
        cable_n[`DSS_LN_STEP] <= 1'b1;
        // Direction held past the trailing edge, never changed at it
        repeat (8) @(posedge clk);
    endtask
endmodule

// ### test_drive_select_step_direction.sv
// Self-checking bench for the drive select and step/direction block.
// Assumes the host model owns the cable; the bench owns APB, straps and reset.
`timescale 1ns/10ps
`include "dss_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_drive_select_step_direction;
    localparam int TMAX = 3;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [`DSS_NUM_LINES-1:0] cable_n;
    logic [3:0] jmp = 4'h4;
    logic motor_step;
    logic motor_inward;
    logic [6:0] track_pos;
    logic drive_selected;
    logic [31:0] rd;
    logic er;
    int error_cnt = 0;
    int tests_run = 0;
    int pulses = 0;
    always #10 clk = ~clk;
    always @(posedge clk) if (motor_step === 1'b1) pulses <= pulses + 1;
    dss_drive_sel #(.ADDR_W(8), .TW(7), .TRACK_MAX(TMAX)) dss_drive_sel_inst (
        .clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cable_n(cable_n),
        .select_addr_jumper_one(jmp[0]), .select_addr_jumper_two(jmp[1]),
        .select_addr_jumper_three(jmp[2]), .select_addr_jumper_four(jmp[3]),
        .motor_step(motor_step), .motor_inward(motor_inward), .track_pos(track_pos),
        .drive_selected(drive_selected));
    dss_host_model dss_host_model_inst (.clk(clk), .cable_n(cable_n));
    // Request held until pready is seen high at a rising edge; data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic [3:0] straps);
        @(posedge clk);
        resetn <= 1'b0;
        jmp <= straps;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    task automatic t_regs;
        apb(0, `DSS_OFF_CTRL, 0);
        `CHK(rd, `DSS_CTRL_RST)
        `CHK(er, 1'b0)
        apb(0, `DSS_OFF_TRACK, 0);
        `CHK(rd, 32'h0)
        apb(0, 8'h14, 0);
        `CHK(er, 1'b1)
        `CHK(rd, 32'h0)
        apb(1, `DSS_OFF_CTRL, 32'hFFFF_FFFF);
        apb(0, `DSS_OFF_CTRL, 0);
        `CHK(rd, 32'h7)
        apb(1, `DSS_OFF_CTRL, `DSS_CTRL_RST);
    endtask
    task automatic t_select;
        for (int i = 0; i <= 4; i++) begin
            if (i != 2) begin
                dss_host_model_inst.sel(i);
                repeat (6) @(negedge clk);
                `CHK(drive_selected, 1'b0)
            end
        end
        dss_host_model_inst.sel(2);
        repeat (6) @(negedge clk);
        `CHK(drive_selected, 1'b1)
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[1:0], 2'b01)
        `CHK(rd[7:4], 4'h4)
    endtask
    task automatic t_steps;
        int p;
        p = pulses;
        dss_host_model_inst.step(0, 60);
        `CHK(pulses, p)
        `CHK(track_pos, 7'h00)
        for (int i = 0; i <= TMAX; i++) dss_host_model_inst.step(1, 60);
        `CHK(pulses, p + TMAX)
        `CHK(track_pos, 7'(TMAX))
        `CHK(motor_inward, 1'b1)
        dss_host_model_inst.step(0, 60);
        `CHK(track_pos, 7'(TMAX - 1))
        `CHK(motor_inward, 1'b0)
        `CHK(pulses, p + TMAX + 1)
        apb(0, `DSS_OFF_STEPS, 0);
        `CHK(rd, 32'(TMAX + 3))
    endtask
    task automatic t_refuse;
        int p;
        p = pulses;
        dss_host_model_inst.sel(0);
        dss_host_model_inst.step(1, 60);
        `CHK(pulses, p)
        dss_host_model_inst.sel(2);
        apb(1, `DSS_OFF_CTRL, 32'h0);
        dss_host_model_inst.step(1, 60);
        `CHK(pulses, p)
        apb(1, `DSS_OFF_CTRL, `DSS_CTRL_RST);
        `CHK(track_pos, 7'(TMAX - 1))
    endtask
    task automatic t_setup;
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[2], 1'b0)
        // Direction flips 5 cycles before the trailing edge: flagged, step still done
        dss_host_model_inst.step(0, 0);
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[2], 1'b1)
        `CHK(track_pos, 7'(TMAX - 2))
        apb(1, `DSS_OFF_STATUS, 32'h4);
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[2], 1'b0)
        // Exactly 1 us of setup is legal, one cycle less is not
        dss_host_model_inst.step(1, `DSS_DIR_SETUP_CYC - 5);
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[2], 1'b0)
        `CHK(track_pos, 7'(TMAX - 1))
        dss_host_model_inst.step(0, `DSS_DIR_SETUP_CYC - 6);
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[2], 1'b1)
        `CHK(track_pos, 7'(TMAX - 2))
    endtask
    task automatic t_lines;
        dss_host_model_inst.set_line(`DSS_LN_OPT0, 1);
        dss_host_model_inst.set_line(`DSS_LN_OPT1, 1);
        for (int i = 6; i < 10; i++) dss_host_model_inst.set_line(i, 1);
        repeat (4) @(posedge clk);
        apb(0, `DSS_OFF_LINES, 0);
        `CHK(rd[11:10], 2'b00)
        `CHK(rd[9:4], 6'h3C)
        `CHK(rd[3:0], 4'h4)
        apb(1, `DSS_OFF_CTRL, 32'h5);
        apb(0, `DSS_OFF_LINES, 0);
        `CHK(rd[11:10], 2'b01)
        apb(1, `DSS_OFF_CTRL, 32'h7);
        apb(0, `DSS_OFF_LINES, 0);
        `CHK(rd[11:10], 2'b11)
        apb(1, `DSS_OFF_TRACK, 32'h0);
        repeat (2) @(posedge clk);
        apb(0, `DSS_OFF_TRACK, 0);
        `CHK(rd, 32'h0)
    endtask
    task automatic t_fault;
        int p;
        do_reset(4'h2);
        dss_host_model_inst.sel(1);
        repeat (6) @(negedge clk);
        `CHK(drive_selected, 1'b1)
        dss_host_model_inst.sel(3);
        repeat (6) @(negedge clk);
        `CHK(drive_selected, 1'b0)
        do_reset(4'hF);
        p = pulses;
        apb(0, `DSS_OFF_STATUS, 0);
        `CHK(rd[1:0], 2'b10)
        `CHK(rd[7:4], 4'hF)
        `CHK(drive_selected, 1'b0)
        dss_host_model_inst.step(1, 60);
        `CHK(pulses, p)
        `CHK(track_pos, 7'h00)
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        do_reset(4'h4);
        t_regs;
        t_select;
        t_steps;
        t_refuse;
        t_setup;
        t_lines;
        t_fault;
        report_and_stop;
    end
    initial begin
        // Whole run is about a thousand cycles
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end
endmodule
